// File: src/cmpc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the comparator control.
// Assumes: 10 MHz pclk, APB with 32-bit data.
// Notes: Summary of operation follows.
// Summary of operation
// - Inverting-input select bit picks negative pin
// - Comparator output feeds generator auto-shutdown
// - Comparator output also feeds generator restart
// - Filter blocks reversal for nominal 20 ns; the code rounds this up to one 100 ns pclk cycle
// - Port read returns zero on analog pins
// - Control 0 layout; speed select resets 1
// - Comparator-on enables comparator and its inputs
// - Invert bit inverts the reported output
// - Timer sync latches on timer falling edge
// - Enabled edges set sticky flag; set wins
`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH

`define CMPC_OFS_CTRL0 8'h00
`define CMPC_OFS_CTRL1 8'h04
`define CMPC_OFS_ANALOG_SELECT_REGISTER 8'h08
`define CMPC_OFS_DIR 8'h0C
`define CMPC_OFS_PORT 8'h10
`define CMPC_OFS_STAT 8'h14
`define CMPC_OFS_MASK 8'h18

`define CMPC_CTRL0_RESET 8'h04
`define CMPC_CTRL0_WMASK 8'hBF
`define CMPC_CTRL1_RESET 8'h00
`define CMPC_ANALOG_SELECT_REGISTER_RESET 8'h00
`define CMPC_DIR_RESET 8'hFF

`define CMPC_CTRL1_NEG_SEL 0
`define CMPC_CTRL1_RISE_EN 1
`define CMPC_CTRL1_FALL_EN 2
`define CMPC_STAT_RISE 0
`define CMPC_STAT_FALL 1
`define CMPC_OUT_PIN 2

`define CMPC_CLK_MHZ 10
`define CMPC_FILT_NS 20
`define CMPC_FILT_CYC (((`CMPC_FILT_NS * `CMPC_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
	((`CMPC_FILT_NS * `CMPC_CLK_MHZ + 999) / 1000))

`endif

// File: src/cmpc_pkg.sv
// Purpose: Types shared by the comparator control files.
// Assumes: Bit order of control 0 is bit 7 first.
// Notes: Constants live in cmpc_defs.svh.
`default_nettype none
package cmpc_pkg;
	typedef struct packed {
		logic comparator_on;
		logic comparator_result;
		logic output_pin_enable;
		logic output_invert;
		logic glitch_filter_enable;
		logic speed_select;
		logic hysteresis_enable;
		logic timer_sync_enable;
	} cmpc_ctrl0_t;

	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} cmpc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} cmpc_apb_rsp_t;

	typedef struct packed {
		logic shutdown;
		logic restart;
	} cmpc_cog_t;

	typedef struct packed {
		logic enable;
		logic neg_select;
		logic speed_select;
		logic hysteresis_enable;
	} cmpc_analog_t;
endpackage
`default_nettype wire

// File: src/cmpc_sync.sv
// Purpose: Two-flop synchroniser for asynchronous levels.
// Assumes: Each bit is an independent level.
// Notes: Only the second flop is visible outside.
`default_nettype none
module cmpc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			dout <= '0;
		end
		else
		begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule
`default_nettype wire

// File: src/cmpc_filter.sv
// Purpose: Zero latency filter: follows input at once, then holds against reversal.
// Assumes: HOLD is at least one cycle.
// Notes: When disabled the output follows the input one cycle later.
`default_nettype none
module cmpc_filter #(
	parameter int HOLD = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control and data
	input wire logic en,
	input wire logic din,
	output logic dout
);
	logic [7:0] hold_q;
	logic [7:0] hold_d;
	logic dout_d;

	always_comb
	begin
		dout_d = dout;
		hold_d = hold_q;
		if (hold_q != 8'h00)
			hold_d = hold_q - 8'h01;
		if (!en)
		begin
			dout_d = din;
			hold_d = 8'h00;
		end
		else if (din != dout && hold_q == 8'h00)
		begin
			// A change passes with no delay; its reversal waits out the hold
			dout_d = din;
			hold_d = 8'(HOLD);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dout <= 1'b0;
			hold_q <= 8'h00;
		end
		else
		begin
			dout <= dout_d;
			hold_q <= hold_d;
		end
	end
endmodule
`default_nettype wire

// File: src/cmpc_top.sv
// Purpose: Comparator digital control: registers, polarity, filter, timer sync, edges, port mask.
// Assumes: APB slave on pclk; raw comparator and port pins are asynchronous.
// Notes: Every output comes from a flop, so each answers one cycle after its cause.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`include "cmpc_defs.svh"
`default_nettype none
module cmpc_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire cmpc_pkg::cmpc_apb_req_t apb_req,
	output cmpc_pkg::cmpc_apb_rsp_t apb_rsp,
	// Analog front end
	input wire logic cmp_raw,
	output cmpc_pkg::cmpc_analog_t analog_ctrl,
	// Port pins
	input wire logic [7:0] port_pin_in,
	output logic pin_out,
	output logic pin_oe,
	// Timer: one-cycle pulse on the prescaled timer clock falling edge
	input wire logic tmr_clk_fall,
	// Output generator
	output cmpc_pkg::cmpc_cog_t complementary_output_generator,
	// Interrupt
	output logic irq
);
	import cmpc_pkg::*;

	cmpc_ctrl0_t ctrl0_q;
	cmpc_ctrl0_t ctrl0_d;
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl1_d;
	logic [7:0] analog_select_register_q;
	logic [7:0] analog_select_register_d;
	logic [7:0] dir_q;
	logic [7:0] dir_d;
	logic [1:0] stat_q;
	logic [1:0] stat_d;
	logic [1:0] mask_q;
	logic [1:0] mask_d;
	cmpc_apb_rsp_t rsp_d;

	logic raw_s;
	logic [7:0] pins_s;
	logic pol_res;
	logic filt_res;
	logic sync_q;
	logic sync_d;
	logic final_res;
	logic prev_q;
	logic rise_evt;
	logic fall_evt;

	logic acc;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic hit;

	cmpc_analog_t analog_d;
	cmpc_cog_t cog_d;
	logic pin_out_d;
	logic pin_oe_d;
	logic irq_d;

	// Input synchronisers
	cmpc_sync #(
		.WIDTH(1)
	) u_sync_raw (
		.clk(pclk),
		.rst_n(presetn),
		.din(cmp_raw),
		.dout(raw_s)
	);

	cmpc_sync #(
		.WIDTH(8)
	) u_sync_pins (
		.clk(pclk),
		.rst_n(presetn),
		.din(port_pin_in),
		.dout(pins_s)
	);

	// Result path: polarity, then filter, then optional timer latch
	always_comb
	begin
		// An off comparator reads low, so toggling on or off can raise an edge
		pol_res = ctrl0_q.comparator_on & (raw_s ^ ctrl0_q.output_invert);
	end

	cmpc_filter #(
		.HOLD(`CMPC_FILT_CYC)
	) u_filter (
		.clk(pclk),
		.rst_n(presetn),
		.en(ctrl0_q.glitch_filter_enable),
		.din(pol_res),
		.dout(filt_res)
	);

	always_comb
	begin
		sync_d = sync_q;
		if (tmr_clk_fall)
			sync_d = filt_res;
		final_res = ctrl0_q.timer_sync_enable ? sync_q : filt_res;
		rise_evt = final_res & ~prev_q & ctrl1_q[`CMPC_CTRL1_RISE_EN];
		fall_evt = ~final_res & prev_q & ctrl1_q[`CMPC_CTRL1_FALL_EN];
	end

	// Timer latch: holds the result between falling edges of the timer clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_q <= 1'b0;
		end
		else
		begin
			sync_q <= sync_d;
		end
	end

	// Previous result resets to the idle low level, so no false edge follows reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_q <= 1'b0;
		end
		else
		begin
			prev_q <= final_res;
		end
	end

	// APB decode: access phase lasts two cycles, pready is a flop
	always_comb
	begin
		acc = apb_req.psel & apb_req.penable;
		wr = acc & apb_req.pwrite & apb_rsp.pready;
		rd = acc & ~apb_req.pwrite & apb_rsp.pready;
		hit = 1'b1;
		rdata = 32'h0000_0000;
		if (apb_req.paddr == `CMPC_OFS_CTRL0)
			rdata = {24'h00_0000, ctrl0_q};
		else if (apb_req.paddr == `CMPC_OFS_CTRL1)
			rdata = {29'h0000_0000, ctrl1_q[2:0]};
		else if (apb_req.paddr == `CMPC_OFS_ANALOG_SELECT_REGISTER)
			rdata = {24'h00_0000, analog_select_register_q};
		else if (apb_req.paddr == `CMPC_OFS_DIR)
			rdata = {24'h00_0000, dir_q};
		else if (apb_req.paddr == `CMPC_OFS_PORT)
			rdata = {24'h00_0000, pins_s & ~analog_select_register_q};
		else if (apb_req.paddr == `CMPC_OFS_STAT)
			rdata = {30'h0000_0000, stat_q};
		else if (apb_req.paddr == `CMPC_OFS_MASK)
			rdata = {30'h0000_0000, mask_q};
		else
			hit = 1'b0;
	end

	always_comb
	begin
		// Response fields are driven only while pready stands, zero otherwise
		rsp_d = '0;
		if (acc && !apb_rsp.pready)
		begin
			rsp_d.pready = 1'b1;
			rsp_d.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
			rsp_d.pslverr = ~hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			apb_rsp <= '0;
		end
		else
		begin
			apb_rsp <= rsp_d;
		end
	end

	// Register writes
	always_comb
	begin
		ctrl0_d = ctrl0_q;
		ctrl0_d.comparator_result = final_res;
		ctrl1_d = ctrl1_q;
		analog_select_register_d = analog_select_register_q;
		dir_d = dir_q;
		mask_d = mask_q;
		if (wr && apb_req.paddr == `CMPC_OFS_CTRL0)
			ctrl0_d = (apb_req.pwdata[7:0] & `CMPC_CTRL0_WMASK) |
				({1'b0, final_res, 6'h00});
		if (wr && apb_req.paddr == `CMPC_OFS_CTRL1)
			ctrl1_d = {5'h00, apb_req.pwdata[2:0]};
		if (wr && apb_req.paddr == `CMPC_OFS_ANALOG_SELECT_REGISTER)
			analog_select_register_d = apb_req.pwdata[7:0];
		if (wr && apb_req.paddr == `CMPC_OFS_DIR)
			dir_d = apb_req.pwdata[7:0];
		if (wr && apb_req.paddr == `CMPC_OFS_MASK)
			mask_d = apb_req.pwdata[1:0];
	end

	// Sticky edge status: a read clears only the bits it returned, and an edge in the
	// same cycle wins, so no event is lost between data capture and clear
	always_comb
	begin
		stat_d = stat_q;
		if (rd && apb_req.paddr == `CMPC_OFS_STAT)
			stat_d = stat_q & ~apb_rsp.prdata[1:0];
		if (rise_evt)
			stat_d[`CMPC_STAT_RISE] = 1'b1;
		if (fall_evt)
			stat_d[`CMPC_STAT_FALL] = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stat_q <= 2'b00;
		end
		else
		begin
			stat_q <= stat_d;
		end
	end

	// Analog side follows control 0 and control 1
	always_comb
	begin
		analog_d.enable = ctrl0_q.comparator_on;
		// Select is parked low while off since all inputs are then disconnected
		analog_d.neg_select = ctrl0_q.comparator_on & ctrl1_q[`CMPC_CTRL1_NEG_SEL];
		analog_d.speed_select = ctrl0_q.speed_select;
		analog_d.hysteresis_enable = ctrl0_q.hysteresis_enable;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			analog_ctrl <= '0;
		end
		else
		begin
			analog_ctrl <= analog_d;
		end
	end

	// Generator, pin and interrupt
	always_comb
	begin
		cog_d.shutdown = final_res;
		cog_d.restart = final_res;
		pin_out_d = final_res;
		// Driver stays off unless software cleared the pin's direction bit
		pin_oe_d = ctrl0_q.output_pin_enable & ~dir_q[`CMPC_OUT_PIN];
		// Taken from the next status so the level rises with the flag itself
		irq_d = |(stat_d & mask_q);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			complementary_output_generator <= '0;
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			complementary_output_generator <= cog_d;
			pin_out <= pin_out_d;
			pin_oe <= pin_oe_d;
			irq <= irq_d;
		end
	end

	// Software visible registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl0_q <= `CMPC_CTRL0_RESET;
			ctrl1_q <= `CMPC_CTRL1_RESET;
			analog_select_register_q <= `CMPC_ANALOG_SELECT_REGISTER_RESET;
			dir_q <= `CMPC_DIR_RESET;
			mask_q <= 2'b00;
		end
		else
		begin
			ctrl0_q <= ctrl0_d;
			ctrl1_q <= ctrl1_d;
			analog_select_register_q <= analog_select_register_d;
			dir_q <= dir_d;
			mask_q <= mask_d;
		end
	end
endmodule
`default_nettype wire

// File: testbench/cmpc_afe_model.sv
// Purpose: Analog front end beside the comparator control
// Assumes: Input levels are 8-bit codes
// Notes: Output churns while off
`default_nettype none
module cmpc_afe_model (
	// Control and levels
	input wire logic pclk,
	input wire cmpc_pkg::cmpc_analog_t ctl,
	input wire logic [7:0] vp,
	input wire logic [7:0] vn0,
	input wire logic [7:0] vn1,
	// Result
	output logic cmp_raw
);
	timeunit 1ns;
	timeprecision 1ns;
	logic junk = 1'b0;
	always @(posedge pclk)
		junk <= ~junk;
	// Garbage while off, so the block itself must gate it
	assign cmp_raw = ctl.enable ? (vp > (ctl.neg_select ? vn1 : vn0)) : junk;
endmodule
`default_nettype wire

// File: testbench/cmpc_top_chk.sv
// Purpose: Port checker of the comparator control
// Assumes: One clock domain
// Notes: Bound to cmpc_top
`default_nettype none
module cmpc_top_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Ports watched
	input wire cmpc_pkg::cmpc_apb_req_t apb_req,
	input wire cmpc_pkg::cmpc_apb_rsp_t apb_rsp,
	input wire cmpc_pkg::cmpc_analog_t analog_ctrl,
	input wire logic pin_out,
	input wire cmpc_pkg::cmpc_cog_t complementary_output_generator,
	input wire logic irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_rdy_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready held");
	chk_rdy_wait: assert property ($rose(apb_req.penable) && apb_req.psel |=> apb_rsp.pready)
		else $error("pready late");
	chk_rdy_cause: assert property (apb_rsp.pready |-> apb_req.psel && $past(apb_req.penable))
		else $error("pready unasked");
	chk_err_zero: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 0)
		else $error("error data");
	chk_idle_zero: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
		else $error("idle data");
	chk_cog_stop: assert property (complementary_output_generator.shutdown == pin_out)
		else $error("shutdown differs");
	chk_cog_restart: assert property (complementary_output_generator.restart == pin_out)
		else $error("restart differs");
	chk_neg_on: assert property (analog_ctrl.neg_select |-> analog_ctrl.enable)
		else $error("input live while off");
	cover property (irq);
	cover property (apb_rsp.pslverr);
	cover property ($rose(pin_out));
endmodule
bind cmpc_top cmpc_top_chk cmpc_top_chk_inst (.pclk, .presetn, .apb_req, .apb_rsp,
	.analog_ctrl, .pin_out, .complementary_output_generator, .irq);
`default_nettype wire

// File: testbench/cmpc_top_tb.sv
// Purpose: Self-checking bench of the comparator control
// Assumes: Result settles within 8 cycles
// Notes: Seeded random levels and port pins
`default_nettype none
module cmpc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cmpc_pkg::*;
	logic pclk = 1'b0;
	logic presetn, raw, pout, poe, tf, irq, pol, ns, e, err, hy;
	cmpc_apb_req_t req;
	cmpc_apb_rsp_t rsp;
	cmpc_analog_t actl;
	cmpc_cog_t cg;
	logic [7:0] pins, vp, vn0, vn1;
	logic [31:0] r, rd;
	int seed = 44, n_fail = 0, samples_checked = 0, cyc = 0, i, nc, nb;
	cmpc_top cmpc_top_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.cmp_raw(raw), .analog_ctrl(actl), .port_pin_in(pins), .pin_out(pout), .pin_oe(poe),
		.tmr_clk_fall(tf), .complementary_output_generator(cg), .irq(irq));
	cmpc_afe_model cmpc_afe_model_inst (.pclk(pclk), .ctl(actl), .vp(vp), .vn0(vn0),
		.vn1(vn1), .cmp_raw(raw));
	initial
		forever #50 pclk = ~pclk;
	function logic res(input logic p, input logic [7:0] a, input logic [7:0] b);
		res = (a > b) ^ p;
	endfunction
	task stop_test;
		$display("fails %0d checks %0d", n_fail, samples_checked);
		if (n_fail == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task cmp(input string n, input logic [31:0] x, input logic [31:0] s);
		samples_checked++;
		if (x !== s)
		begin
			n_fail++;
			$display("BAD %s exp %h got %h", n, x, s);
		end
	endtask
	// Called just after an edge; request held until pready is sampled
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		@(posedge pclk);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] x, input string n);
		apb(a, 1'b0, 32'h0);
		cmp(n, x, rd);
	endtask
	// Result is undefined until the response time has passed
	task w8;
		repeat (8) @(posedge pclk);
	endtask
	// Toggles the level each cycle for the first 12 of 24 cycles; counts result moves and moves in back-to-back cycles
	task filt_run(output int mv, output int b2b);
		logic last, moved;
		w8();
		mv = 0;
		b2b = 0;
		last = pout;
		moved = 1'b0;
		for (i = 0; i < 24; i++)
		begin
			if (i < 12)
				vp <= ~vp;
			@(posedge pclk);
			if (pout !== last)
			begin
				mv++;
				if (moved)
					b2b++;
			end
			moved = (pout !== last);
			last = pout;
		end
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			stop_test;
		end
	end
	initial
	begin
		req = '0;
		presetn = 1'b0;
		{vp, pins, tf} = '0;
		vn0 = 8'h80;
		vn1 = 8'h40;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(8'h00, 32'h04, "ctrl0 rst");
		rdc(8'h0C, 32'hFF, "dir rst");
		apb(8'h1C, 1'b0, 32'h0);
		cmp("unmapped", 32'h1, {31'h0, err});
		$display("test reset done");
		apb(8'h08, 1'b1, 32'h03);
		apb(8'h0C, 1'b1, 32'hFB);
		for (i = 0; i < 6; i++)
		begin
			r = $random(seed);
			{hy, pol, ns} = r[2:0];
			vp <= r[15:8];
			apb(8'h04, 1'b1, {31'h0, ns});
			// Bit 6 written high must stay the live result
			apb(8'h00, 1'b1, {24'h0, 3'b111, pol, 2'b01, hy, 1'b0});
			w8();
			e = res(pol, vp, ns ? vn1 : vn0);
			rdc(8'h00, {24'h0, 1'b1, e, 1'b1, pol, 2'b01, hy, 1'b0}, "ctrl0");
			cmp("ana on", {28'h0, 1'b1, ns, 1'b1, hy}, {28'h0, actl});
			cmp("pin", {30'h0, e, 1'b1}, {30'h0, pout, poe});
			cmp("cog", {30'h0, e, e}, {30'h0, cg});
		end
		$display("test result done");
		apb(8'h04, 1'b1, 32'h3);
		apb(8'h00, 1'b1, 32'h0);
		w8();
		rdc(8'h00, 32'h0, "off");
		cmp("ana", 32'h0, {29'h0, actl.enable, actl.neg_select, poe});
		vp <= 8'h00;
		apb(8'h18, 1'b1, 32'h1);
		apb(8'h00, 1'b1, 32'h88);
		w8();
		apb(8'h14, 1'b0, 32'h0);
		vp <= 8'hFF;
		w8();
		cmp("irq set", 32'h1, {31'h0, irq});
		rdc(8'h14, 32'h1, "stat");
		repeat (2) @(posedge pclk);
		cmp("irq clr", 32'h0, {31'h0, irq});
		apb(8'h18, 1'b1, 32'h0);
		vp <= 8'h00;
		w8();
		vp <= 8'hFF;
		w8();
		cmp("irq mask", 32'h0, {31'h0, irq});
		rdc(8'h14, 32'h1, "stat mask");
		$display("test irq done");
		apb(8'h00, 1'b1, 32'h81);
		tf <= 1'b1;
		@(posedge pclk);
		tf <= 1'b0;
		vp <= 8'h00;
		w8();
		rdc(8'h00, 32'hC1, "sync hold");
		tf <= 1'b1;
		@(posedge pclk);
		tf <= 1'b0;
		w8();
		rdc(8'h00, 32'h81, "sync take");
		$display("test sync done");
		apb(8'h00, 1'b1, 32'h88);
		filt_run(nc, nb);
		cmp("filt moves", 32'h4, nc);
		cmp("filt reversals", 32'h0, nb);
		apb(8'h00, 1'b1, 32'h80);
		filt_run(nc, nb);
		cmp("raw moves", 32'hC, nc);
		$display("test filter done");
		for (i = 0; i < 4; i++)
		begin
			r = $random(seed);
			pins <= r[7:0];
			apb(8'h08, 1'b1, {24'h0, r[15:8]});
			rdc(8'h10, {24'h0, r[7:0] & ~r[15:8]}, "port");
		end
		$display("test port done");
		stop_test;
	end
endmodule
`default_nettype wire
